//--- pwdb_compare.sv
`timescale 1ns/1ps
`default_nettype none
module pwdb_compare
(
  input wire logic [9:0] duty,
  input wire logic [7:0] count,
  input wire logic [1:0] ext_bits,
  output logic hit
);
  // Ten-bit match against counter plus sub-cycle bits
  assign hit = (duty == {count, ext_bits}); // RULE13
endmodule : pwdb_compare
`default_nettype wire

//--- pwdb_load.sv
`timescale 1ns/1ps
`default_nettype none
module pwdb_load
(
  input wire logic clk,
  input wire logic rst,
  input wire logic pwm_out,
  input wire logic pwm_oe,
  output logic pin,
  output var int high_len,
  output var int period_len,
  output var int pulses
);
  logic last_q;
  int hi_q;
  int per_q;
  // Pull-down on the trace: an undriven pin reads low
  assign pin = pwm_oe ? pwm_out : 1'b0;
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      last_q <= 1'b0;
      pulses <= 0;
    end
    else
    begin
      last_q <= pin;
      per_q <= (pin && !last_q) ? 1 : per_q + 1;
      hi_q <= pin ? hi_q + 1 : 0;
      if (pin && !last_q)
        period_len <= per_q;
      if (!pin && last_q)
      begin
        high_len <= hi_q;
        pulses <= pulses + 1;
      end
    end
  end
endmodule : pwdb_load
`default_nettype wire

//--- pwdb_pkg.sv
// Functional notes
// (RULE1) PWM mode drives the output pin with up to 10-bit duty resolution.
// (RULE2) Software clears the pin direction bit so the waveform reaches the pin.
// (RULE3) Clearing channel control forces the channel output latch low, port latch untouched.
// (RULE4) Period comes from period_reg; counter counts up to it.
// (RULE5) On counter equal to period, next increment clears the counter.
// (RULE6) New period sets the pin high unless duty is zero.
// (RULE7) At period end the duty value is copied into the active buffer.
// (RULE8) Postscaler does not affect PWM period or frequency.
// (RULE9) Duty is duty_high_bits_reg as MSBs and control bits 5:4 as LSBs.
// (RULE10) Duty writes accepted anytime, take effect only after a period match.
// (RULE11) Active duty buffer is readable but ignores writes in PWM mode.
// (RULE12) Active duty held in 8-bit buffer plus a 2-bit internal latch.
// (RULE13) Pin clears when buffered duty equals counter extended by two phase bits.
// (RULE14) Duty longer than period never clears the pin; output stays high.
// (RULE15) Counter prescaler divides the instruction clock by one, four or sixteen.
// (RULE16) Software sets period, duty, pin direction, prescale and timer, then PWM mode.
// (RULE17) Extension bits: quarter phase at prescale one, else prescaler top bits.
package pwdb_pkg;
  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [11:0] PWDB_OFS_DUTY_HI = 12'h000;
  localparam logic [11:0] PWDB_OFS_ACTIVE = 12'h004;
  localparam logic [11:0] PWDB_OFS_CTRL = 12'h008;
  localparam logic [11:0] PWDB_OFS_PERIOD = 12'h00C;
  localparam logic [11:0] PWDB_OFS_TIMER_CTRL = 12'h010;
  localparam logic [11:0] PWDB_OFS_COUNTER = 12'h014;
  localparam logic [11:0] PWDB_OFS_DIR = 12'h018;
  // ----------------------------------------
  // Fields
  // ----------------------------------------
  localparam int PWDB_CTRL_DUTY_LO_POS = 4;
  localparam int PWDB_CTRL_MODE_POS = 0;
  localparam int PWDB_TC_ON_POS = 2;
  localparam int PWDB_TC_PS_POS = 0;
  localparam int PWDB_TC_POST_POS = 3;
  localparam logic [3:0] PWDB_MODE_PWM = 4'hC;
  localparam logic [7:0] PWDB_CTRL_RST = 8'h00;
  localparam logic [7:0] PWDB_PERIOD_RST = 8'hFF;
  localparam logic [7:0] PWDB_TC_RST = 8'h00;
  localparam logic [7:0] PWDB_DUTY_RST = 8'h00;
  localparam logic PWDB_DIR_RST = 1'b1;
  // ----------------------------------------
  // Prescale selections
  // ----------------------------------------
  typedef enum logic [1:0] {PWDB_PS_1 = 2'h0, PWDB_PS_4 = 2'h1, PWDB_PS_16 = 2'h2,
    PWDB_PS_16B = 2'h3} pwdb_ps_t;
  localparam logic [1:0] PWDB_QPHASE_LAST = 2'h3;
endpackage : pwdb_pkg

//--- pwdb_prescaler.sv
`timescale 1ns/1ps
`default_nettype none
module pwdb_prescaler
  import pwdb_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic run,
  input wire logic [1:0] ps_sel,
  output logic tick,
  output logic [1:0] ext_bits
);
  logic [1:0] qphase_q;
  logic [3:0] div_q;
  logic qend;
  logic div_end;

  // ----------------------------------------
  // Quarter-cycle phase and divider
  // ----------------------------------------
  assign qend = (qphase_q == PWDB_QPHASE_LAST);

  always_ff @(posedge clk)
  begin
    if (rst || !run)
      qphase_q <= 2'h0;
    else
      qphase_q <= qphase_q + 2'h1;
  end

  always_ff @(posedge clk)
  begin
    if (rst || !run)
      div_q <= 4'h0;
    else if (qend)
    begin
      if (div_end)
        div_q <= 4'h0;
      else
        div_q <= div_q + 4'h1;
    end
  end

  // Ratios one, four, sixteen of the instruction clock
  always_comb
  begin
    case (ps_sel)
      PWDB_PS_1: div_end = 1'b1; // RULE15
      PWDB_PS_4: div_end = (div_q[1:0] == 2'h3); // RULE15
      default: div_end = (div_q == 4'hF); // RULE15
    endcase
  end

  assign tick = run && qend && div_end;

  // Sub-cycle bits so duty compares in oscillator units times the prescale
  always_comb
  begin
    case (ps_sel)
      PWDB_PS_1: ext_bits = qphase_q; // RULE17
      PWDB_PS_4: ext_bits = div_q[1:0]; // RULE17
      default: ext_bits = div_q[3:2]; // RULE17
    endcase
  end
endmodule : pwdb_prescaler
`default_nettype wire

//--- pwdb_top.sv
`timescale 1ns/1ps
`default_nettype none
module pwdb_top
  import pwdb_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic pwm_out,
  output logic pwm_oe,
  output logic period_tick
);
  import pwdb_pkg::*;

  logic [7:0] duty_hi_q;
  logic [7:0] active_q;
  logic [1:0] active_lo_q;
  logic [7:0] ctrl_q;
  logic [7:0] period_q;
  logic [7:0] tctrl_q;
  logic [7:0] count_q;
  logic dir_q;
  logic latch_q;
  logic [3:0] post_q;
  logic [31:0] prdata_q;
  logic rd_done_q;
  logic wrap_q;
  logic wr;
  logic rd;
  logic pwm_mode;
  logic run;
  logic tick;
  logic [1:0] ext_bits;
  logic match;
  logic wrap;
  logic hit;
  logic [9:0] duty_next;
  logic in_map;

  // ----------------------------------------
  // APB slave
  // ----------------------------------------
  assign wr = psel && penable && pwrite;
  assign rd = psel && penable && !pwrite;

  // One wait state on reads, so registered read data stands when pready is high
  always_ff @(posedge clk)
  begin
    if (rst)
      rd_done_q <= 1'b0;
    else
      rd_done_q <= rd && !rd_done_q;
  end

  assign pready = !rd || rd_done_q;

  always_comb
  begin
    if (paddr == PWDB_OFS_DUTY_HI)
      in_map = 1'b1;
    else if (paddr == PWDB_OFS_ACTIVE)
      in_map = 1'b1;
    else if (paddr == PWDB_OFS_CTRL)
      in_map = 1'b1;
    else if (paddr == PWDB_OFS_PERIOD)
      in_map = 1'b1;
    else if (paddr == PWDB_OFS_TIMER_CTRL)
      in_map = 1'b1;
    else if (paddr == PWDB_OFS_COUNTER)
      in_map = 1'b1;
    else if (paddr == PWDB_OFS_DIR)
      in_map = 1'b1;
    else
      in_map = 1'b0;
  end

  assign pslverr = psel && penable && !in_map;

  // Duty registers take writes at any time
  always_ff @(posedge clk)
  begin
    if (rst)
      duty_hi_q <= PWDB_DUTY_RST;
    else if (wr && paddr == PWDB_OFS_DUTY_HI)
      duty_hi_q <= pwdata[7:0]; // RULE10
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      ctrl_q <= PWDB_CTRL_RST;
    else if (wr && paddr == PWDB_OFS_CTRL)
      ctrl_q <= {2'h0, pwdata[5:0]};
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      period_q <= PWDB_PERIOD_RST;
    else if (wr && paddr == PWDB_OFS_PERIOD)
      period_q <= pwdata[7:0]; // RULE4
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      tctrl_q <= PWDB_TC_RST;
    else if (wr && paddr == PWDB_OFS_TIMER_CTRL)
      tctrl_q <= {1'b0, pwdata[6:0]};
  end

  // Direction bit: one means input, pin released
  always_ff @(posedge clk)
  begin
    if (rst)
      dir_q <= PWDB_DIR_RST;
    else if (wr && paddr == PWDB_OFS_DIR)
      dir_q <= pwdata[0];
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      prdata_q <= 32'h0000_0000;
    else if (rd && !rd_done_q)
    begin
      if (paddr == PWDB_OFS_DUTY_HI)
        prdata_q <= {24'h000000, duty_hi_q};
      else if (paddr == PWDB_OFS_ACTIVE)
        prdata_q <= {24'h000000, active_q}; // RULE11
      else if (paddr == PWDB_OFS_CTRL)
        prdata_q <= {24'h000000, ctrl_q};
      else if (paddr == PWDB_OFS_PERIOD)
        prdata_q <= {24'h000000, period_q};
      else if (paddr == PWDB_OFS_TIMER_CTRL)
        prdata_q <= {24'h000000, tctrl_q};
      else if (paddr == PWDB_OFS_COUNTER)
        prdata_q <= {24'h000000, count_q};
      else if (paddr == PWDB_OFS_DIR)
        prdata_q <= {24'h000000, 7'h00, dir_q};
      else
        prdata_q <= 32'h0000_0000;
    end
  end

  // Loaded in the wait state, held until the next read
  assign prdata = prdata_q;

  // ----------------------------------------
  // Period timer
  // ----------------------------------------
  assign run = tctrl_q[PWDB_TC_ON_POS];
  assign pwm_mode = (ctrl_q[3:0] == PWDB_MODE_PWM);

  pwdb_prescaler u_ps
  (
    .clk(clk),
    .rst(rst),
    .run(run),
    .ps_sel(tctrl_q[PWDB_TC_PS_POS +: 2]),
    .tick(tick),
    .ext_bits(ext_bits)
  );

  assign match = (count_q == period_q);
  assign wrap = tick && match;

  always_ff @(posedge clk)
  begin
    if (rst)
      count_q <= 8'h00;
    else if (wr && paddr == PWDB_OFS_COUNTER)
      count_q <= pwdata[7:0];
    else if (wrap)
      count_q <= 8'h00; // RULE5
    else if (tick)
      count_q <= count_q + 8'h01; // RULE4
  end

  // Postscaler only paces the period tick output, never the PWM
  always_ff @(posedge clk)
  begin
    if (rst || !run)
      post_q <= 4'h0;
    else if (wrap)
    begin
      if (post_q == tctrl_q[PWDB_TC_POST_POS +: 4])
        post_q <= 4'h0; // RULE8
      else
        post_q <= post_q + 4'h1;
    end
  end

  assign period_tick = wrap && (post_q == tctrl_q[PWDB_TC_POST_POS +: 4]); // RULE8

  // ----------------------------------------
  // Duty double buffer
  // ----------------------------------------
  assign duty_next = {duty_hi_q, ctrl_q[PWDB_CTRL_DUTY_LO_POS +: 2]}; // RULE9

  // Active buffer has no write path, so bus writes are ignored
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      active_q <= PWDB_DUTY_RST;
      active_lo_q <= 2'h0;
    end
    else if (wrap)
    begin
      active_q <= duty_next[9:2]; // RULE7 RULE12
      active_lo_q <= duty_next[1:0]; // RULE12
    end
  end

  pwdb_compare u_cmp
  (
    .duty({active_q, active_lo_q}),
    .count(count_q),
    .ext_bits(ext_bits),
    .hit(hit)
  );

  // ----------------------------------------
  // Output latch
  // ----------------------------------------
  // Set trails the wrap by one cycle, as the clear trails its match,
  // so the high time is exactly the duty count
  always_ff @(posedge clk)
  begin
    if (rst)
      wrap_q <= 1'b0;
    else
      wrap_q <= wrap;
  end

  // Long duty never hits within the period, so output stays high
  always_ff @(posedge clk)
  begin
    if (rst || ctrl_q == 8'h00)
      latch_q <= 1'b0; // RULE3
    else if (!pwm_mode)
      latch_q <= 1'b0;
    else if (wrap_q)
      latch_q <= ({active_q, active_lo_q} != 10'h000); // RULE6 RULE7
    else if (run && hit)
      latch_q <= 1'b0; // RULE13 RULE14
  end

  assign pwm_out = latch_q; // RULE1
  assign pwm_oe = !dir_q; // RULE2
endmodule : pwdb_top
`default_nettype wire

//--- pwdb_top_sva.sv
`timescale 1ns/1ps
`default_nettype none
module pwdb_chk
  import pwdb_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic pwm_out,
  input wire logic pwm_oe,
  input wire logic period_tick
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  wire logic acc = psel && penable;
  wire logic wr = acc && pwrite;
  // ----
  // Checks
  // ----
  ctrl_clear_a: assert property (wr && paddr == PWDB_OFS_CTRL && pwdata[7:0] == 8'h00 |=>
    ##1 !pwm_out [*2]) else $error("output not forced low");
  oe_on_a: assert property ($rose(pwm_oe) |->
    $past(wr && paddr == PWDB_OFS_DIR && !pwdata[0])) else $error("oe rose unasked");
  oe_off_a: assert property ($fell(pwm_oe) |->
    $past(wr && paddr == PWDB_OFS_DIR && pwdata[0])) else $error("oe fell unasked");
  zero_wait_a: assert property (acc && pwrite |-> pready) else $error("wait state");
  rd_first_a: assert property (acc && !pwrite && !$past(acc) |-> !pready)
    else $error("read without wait state");
  rd_wait_a: assert property (acc && !pwrite && !pready |=> pready) else $error("read wait too long");
  bad_addr_a: assert property (acc && paddr > PWDB_OFS_DIR |-> pslverr) else $error("no error");
  good_addr_a: assert property (acc && paddr <= PWDB_OFS_DIR && paddr[1:0] == 2'h0 |-> !pslverr)
    else $error("false error");
  rd_hold_a: assert property (!$past(acc && !pwrite) |-> $stable(prdata)) else $error("prdata moved");
  tick_gap_a: assert property (period_tick |=> !period_tick [*3]) else $error("ticks too close");
  cover property ($rose(pwm_out));
  cover property ($fell(pwm_out));
  cover property (acc && pslverr);
  cover property (acc && !pwrite && !pready);
endmodule : pwdb_chk
bind pwdb_top pwdb_chk i_chk (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
  .pready, .pslverr, .pwm_out, .pwm_oe, .period_tick);
`default_nettype wire

//--- pwdb_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module pwdb_top_tb;
  import pwdb_pkg::*;
  logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, err;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, pwm_out, pwm_oe, period_tick, pin;
  int high_len, period_len, pulses, f, t0, ticks = 0, failures = 0, tests_run = 0, cycles = 0;
  pwdb_top i_dut (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .pwm_out, .pwm_oe, .period_tick);
  pwdb_load i_load (.clk, .rst, .pwm_out, .pwm_oe, .pin, .high_len, .period_len, .pulses);
  initial forever #2 clk = ~clk;
  // Hang guard, well above the longest run
  always @(posedge clk)
  begin
    cycles++;
    if (period_tick)
      ticks++;
    if (cycles == 30000)
    begin
      failures++;
      tally_and_finish();
    end
  end
  // ----
  // Helpers
  // ----
  task tally_and_finish;
    if (failures == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : tally_and_finish
  task check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  // Request held until pready is seen high; read data taken at that edge
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    err = pslverr;
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  task setup(input logic [1:0] ps, input logic [3:0] post, input logic [7:0] pr,
    input logic [9:0] d);
    apb(1'b1, PWDB_OFS_PERIOD, {24'h0, pr});
    apb(1'b1, PWDB_OFS_DUTY_HI, {24'h0, d[9:2]});
    apb(1'b1, PWDB_OFS_DIR, 32'h0);
    apb(1'b1, PWDB_OFS_TIMER_CTRL, {25'h0, post, 1'b1, ps});
    apb(1'b1, PWDB_OFS_CTRL, {26'h0, d[1:0], PWDB_MODE_PWM});
  endtask : setup
  // ----
  // Scenarios
  // ----
  task t_resets;
    logic [11:0] ofs [5] = '{PWDB_OFS_DUTY_HI, PWDB_OFS_CTRL, PWDB_OFS_PERIOD,
      PWDB_OFS_TIMER_CTRL, PWDB_OFS_DIR};
    logic [31:0] rv [5] = '{32'h0, 32'h0, 32'hFF, 32'h0, 32'h1};
    for (int i = 0; i < 5; i++)
    begin
      apb(1'b0, ofs[i], 32'h0);
      check(rd, rv[i]);
    end
    apb(1'b0, 12'h020, 32'h0);
    check({31'h0, err}, 32'h1);
    check(rd, 32'h0);
  endtask : t_resets
  // Each prescale, with a different postscale each time
  task t_rates;
    for (int i = 0; i < 3; i++)
    begin
      setup(2'(i), 4'(i * 5), 8'h03, 10'h006);
      f = pulses;
      wait (pulses == f + 3);
      check(high_len, 6 << (2 * i));
      check(period_len, 16 << (2 * i));
      t0 = ticks;
      wait (pulses == f + 4 + i * 5);
      check(ticks - t0, 1);
    end
  endtask : t_rates
  task t_dbl;
    setup(2'h0, 4'h0, 8'h03, 10'h006);
    repeat (40) @(posedge clk);
    @(posedge pin);
    f = pulses;
    @(posedge clk);
    apb(1'b1, PWDB_OFS_DUTY_HI, 32'h2);
    apb(1'b1, PWDB_OFS_CTRL, {26'h0, 2'h2, PWDB_MODE_PWM});
    wait (pulses == f + 1);
    check(high_len, 6);
    wait (pulses == f + 2);
    check(high_len, 10);
    @(posedge clk);
    apb(1'b1, PWDB_OFS_ACTIVE, 32'hFF);
    apb(1'b0, PWDB_OFS_ACTIVE, 32'h0);
    check(rd, 32'h2);
  endtask : t_dbl
  task t_hold(input logic [9:0] d, input logic exp);
    setup(2'h0, 4'h0, 8'h03, d);
    repeat (48) @(posedge clk);
    repeat (20)
    begin
      check({31'h0, pin}, {31'h0, exp});
      @(posedge clk);
    end
  endtask : t_hold
  task t_clear;
    apb(1'b1, PWDB_OFS_CTRL, 32'h0);
    repeat (10)
    begin
      @(posedge clk);
      check({31'h0, pin}, 32'h0);
    end
  endtask : t_clear
  initial
  begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_resets();
    t_rates();
    t_dbl();
    t_hold(10'h000, 1'b0);
    t_hold(10'h050, 1'b1);
    t_clear();
    tally_and_finish();
  end
endmodule : pwdb_top_tb
`default_nettype wire
